//--- cmg_gain_stage.sv
// Dynamic range and mode gain stage with an Avalon-MM register slave
//
// Overview of operation
// RQ1 - Line mode normalizes dialog to -31 dBFS average.
// RQ2 - Downmixed output puts dialog target 3 dB lower in both modes.
// RQ3 - Line mode uses light word; cut scaled only undownmixed; boost scaled.
// RQ4 - Modulator mode normalizes dialog to -20 dBFS average.
// RQ5 - Modulator mode uses heavy word, light word when heavy absent.
// RQ6 - Modulator mode ignores scale factors, always full compression.
// RQ7 - Modulator mode raises whole program level by 11 dB.
// RQ8 - Modulator mode limits peaks to 20 dB above dialog, 23 downmixed.
// RQ9 - Custom mode still offers settings equal to the mandatory ones.
// RQ10 - Standard range preset: line mode, factors 1.0/1.0, no correction.
// RQ11 - Source with modulated output also offers minimum range preset.
// RQ12 - Modulated-output-only source may offer just the minimum preset.
// RQ13 - Maximum preset is line 0.0/0.0; downmix keeps cut for overload.
// RQ14 - Decoder product offers standard and maximum presets, minimum too.
// RQ15 - Decoder in modulator mode applies 11 dB gain reduction.
// RQ16 - Variable control sets scale factors anywhere in 0.0 to 1.0.
// RQ17 - Variable control moves both factors together or separately.
// RQ18 - Variable control steps in 0.1 units.
// RQ19 - Variable control has exact 0.0/0.0 and 1.0/1.0 positions.
// RQ20 - While downmixing the low frequency effects channel is dropped.
// RQ21 - One combined per-block gain applies to every channel sample.
//
// Design decisions made here: the Avalon-MM register port and the address map.
`timescale 1ns/100ps
`include "cmg_defines.svh"

module cmg_gain_stage
    import cmg_pkg::*;
(
    input  wire logic               ref_clk,
    input  wire logic               reset_n,
    input  wire logic [3:0]         avs_address,
    input  wire logic               avs_read,
    input  wire logic               avs_write,
    input  wire logic [31:0]        avs_writedata,
    input  wire logic [3:0]         avs_byteenable,
    output logic      [31:0]        avs_readdata,
    output logic                    avs_waitrequest,
    input  wire logic               in_valid,
    output logic                    in_ready,
    input  wire logic signed [23:0] in_sample,
    input  wire logic [2:0]         in_chan,
    input  wire logic               in_block_start,
    input  wire logic [4:0]         in_dialnorm,
    input  wire logic [7:0]         in_light_word,
    input  wire logic [7:0]         in_heavy_word,
    input  wire logic               in_heavy_present,
    input  wire logic               in_downmix,
    output logic                    out_valid,
    input  wire logic               out_ready,
    output logic signed [23:0]      out_sample,
    output logic [2:0]              out_chan
);

    // ****************************************************************
    // Helper functions
    // ****************************************************************

    // Scale a quarter-dB word by tenths, truncating toward zero
    function automatic logic signed [10:0] scale_db(
        input logic signed [7:0] word,
        input logic [3:0]        tenths
    );
        logic [7:0]  mag;
        logic [11:0] prod;
        logic [10:0] res;
        mag  = word[7] ? 8'(-word) : word;
        prod = 12'(mag) * 12'(tenths);
        res  = 11'(prod / 12'd10);
        return word[7] ? -$signed(res) : $signed(res);
    endfunction

    // Mantissa of 10^(r/80) in Q15 for one quarter-dB step r
    function automatic logic [15:0] mant_of(input logic [4:0] r);
        logic [15:0] m;
        m = 16'h8000;
        case (r)
            5'd1:  m = 16'd33725;
            5'd2:  m = 16'd34711;
            5'd3:  m = 16'd35725;
            5'd4:  m = 16'd36766;
            5'd5:  m = 16'd37841;
            5'd6:  m = 16'd38946;
            5'd7:  m = 16'd40083;
            5'd8:  m = 16'd41252;
            5'd9:  m = 16'd42458;
            5'd10: m = 16'd43698;
            5'd11: m = 16'd44974;
            5'd12: m = 16'd46287;
            5'd13: m = 16'd47638;
            5'd14: m = 16'd49029;
            5'd15: m = 16'd50459;
            5'd16: m = 16'd51934;
            5'd17: m = 16'd53451;
            5'd18: m = 16'd55011;
            5'd19: m = 16'd56618;
            5'd20: m = 16'd58270;
            5'd21: m = 16'd59972;
            5'd22: m = 16'd61723;
            5'd23: m = 16'd63527;
            default: m = 16'h8000;
        endcase
        return m;
    endfunction

    // ****************************************************************
    // Register file and bus slave
    // ****************************************************************
    logic [7:0]  ctrl;
    logic [3:0]  scale_high;
    logic [3:0]  scale_low;
    logic        bus_ack;
    logic signed [10:0] blk_gain;
    logic        blk_dmx;
    logic        blk_mod;
    logic        blk_heavy;

    wire bus_req   = avs_read || avs_write;
    wire wr_ctrl   = avs_write && bus_ack && avs_address == `CMG_OFS_CTRL;
    wire wr_scale  = avs_write && bus_ack && avs_address == `CMG_OFS_SCALE;
    wire [31:0] status_word = {5'h0, blk_gain, 13'h0,
                               blk_heavy, blk_dmx, blk_mod};
    wire [31:0] next_readdata =
        avs_address == `CMG_OFS_CTRL   ? {24'h0, ctrl} :
        avs_address == `CMG_OFS_SCALE  ? {20'h0, scale_low, 4'h0,
                                          scale_high} :
        avs_address == `CMG_OFS_STATUS ? status_word : 32'h0;

    // One wait state on every access
    assign avs_waitrequest = bus_req && !bus_ack;

    // Bus handshake and read data
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            bus_ack      <= 1'b0;
            avs_readdata <= 32'h0;
        end else begin
            bus_ack      <= bus_req && !bus_ack;
            avs_readdata <= next_readdata;
        end
    end

    // Register writes by byte lane
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            ctrl       <= `CMG_CTRL_RESET;
            scale_high <= `CMG_SCALE_RESET;
            scale_low  <= `CMG_SCALE_RESET;
        end else begin
            if (wr_ctrl && avs_byteenable[0])
                ctrl <= avs_writedata[7:0];
            if (wr_scale && avs_byteenable[0])
                scale_high <= avs_writedata[`CMG_SCALE_HIGH_LSB +: 4];
            if (wr_scale && avs_byteenable[1])
                scale_low <= avs_writedata[`CMG_SCALE_LOW_LSB +: 4];
        end
    end

    // ****************************************************************
    // Preset and mode selection
    // ****************************************************************
    wire cmg_op_t     op_sel  = cmg_op_t'(ctrl[`CMG_CTRL_MODE_LSB +: 2]);
    wire cmg_preset_t pre_raw = cmg_preset_t'(ctrl[`CMG_CTRL_PRESET_LSB +: 2]);
    wire rf_only  = ctrl[`CMG_CTRL_RF_ONLY];
    wire decoder  = ctrl[`CMG_CTRL_DECODER];
    wire tandem   = ctrl[`CMG_CTRL_TANDEM];

    // Modulated-only source runs the minimum preset alone
    wire cmg_preset_t preset = rf_only ? CMG_PRE_MIN : pre_raw;  // RQ12
    // Minimum preset always reachable; variable honours modulator op
    wire mod_mode = preset == CMG_PRE_MIN ||                     // RQ11 RQ14
                    (preset == CMG_PRE_VAR && op_sel == CMG_OP_MOD);
    // Custom and line ops share line settings in every preset but minimum     RQ9

    // Variable factors clamp at 1.0, tandem copies the high factor
    wire [3:0] var_high = scale_high > `CMG_SCALE_FULL ?             // RQ16
                          `CMG_SCALE_FULL : scale_high;              // RQ18
    wire [3:0] var_low_raw = tandem ? scale_high : scale_low;        // RQ17
    wire [3:0] var_low = var_low_raw > `CMG_SCALE_FULL ?             // RQ16
                         `CMG_SCALE_FULL : var_low_raw;              // RQ19

    // Factor pair per preset
    wire [3:0] line_high = preset == CMG_PRE_STD ? `CMG_SCALE_FULL : // RQ10
                           preset == CMG_PRE_MAX ? 4'h0 : var_high;  // RQ13
    wire [3:0] line_low  = preset == CMG_PRE_STD ? `CMG_SCALE_FULL : // RQ10
                           preset == CMG_PRE_MAX ? 4'h0 : var_low;   // RQ13
    // Modulator mode forces full compression
    wire [3:0] eff_high = mod_mode ? `CMG_SCALE_FULL : line_high;    // RQ6
    wire [3:0] eff_low  = mod_mode ? `CMG_SCALE_FULL : line_low;     // RQ6

    // ****************************************************************
    // Per-block gain in quarter dB
    // ****************************************************************
    wire [4:0] dn = in_dialnorm == 5'h0 ? `CMG_DN_DEFAULT : in_dialnorm;
    // Dialog at -31 dBFS in line mode, the modulator shift moves it to -20
    wire signed [10:0] norm_db = $signed({4'h0, dn, 2'b00})
                                 - `CMG_LINE_TARGET_DB;            // RQ1
    wire use_heavy = mod_mode && in_heavy_present;                 // RQ5
    wire signed [7:0] comp_word = use_heavy ? $signed(in_heavy_word)
                                            : $signed(in_light_word); // RQ3
    // Cut held full while downmixing in line mode for overload
    wire [3:0] cut_fac = in_downmix ? `CMG_SCALE_FULL : eff_high;   // RQ3
    wire [3:0] sel_fac = comp_word[7] ? cut_fac : eff_low;          // RQ3
    wire signed [10:0] comp_db = scale_db(comp_word, sel_fac);
    wire signed [10:0] mode_db = mod_mode ? `CMG_MOD_SHIFT_DB     // RQ4 RQ7
                                          : 11'sd0;
    wire signed [10:0] corr_db = (mod_mode && decoder) ?
                                 `CMG_DEC_CORR_DB : 11'sd0;         // RQ15
    wire signed [10:0] dmx_db  = in_downmix ? `CMG_DMX_OFFSET_DB
                                            : 11'sd0;               // RQ2
    // Single combined gain for the block
    wire signed [10:0] next_gain = norm_db + comp_db + mode_db
                                   - corr_db - dmx_db;              // RQ21

    // ****************************************************************
    // Sample path
    // ****************************************************************
    wire take      = in_valid && in_ready;
    wire new_block = take && in_block_start;
    wire signed [10:0] cur_gain = in_block_start ? next_gain : blk_gain;
    wire cur_dmx = in_block_start ? in_downmix : blk_dmx;
    wire cur_corr = in_block_start ? (mod_mode && decoder) :
                    (blk_mod && decoder);
    // Downmix discards the effects channel
    wire drop = cur_dmx && in_chan == `CMG_LFE_CHAN;                // RQ20

    // Split gain into octave exponent and quarter-dB step
    wire [10:0] gain_biased = 11'(cur_gain + `CMG_EXP_BIAS);
    wire [5:0]  exp_biased  = 6'(gain_biased / 11'd24);
    wire [4:0]  step        = 5'(gain_biased - 11'(exp_biased) * 11'd24);
    wire signed [5:0] exp_raw = $signed(exp_biased) - 6'sd20;
    wire signed [5:0] exp_cl  = exp_raw > `CMG_EXP_MAX ? `CMG_EXP_MAX
                                                       : exp_raw;
    wire [5:0]  shift_amt = 6'(6'sd15 - exp_cl);

    // Same multiplier for every channel of the block
    wire signed [40:0] product = in_sample * $signed({1'b0,
                                 mant_of(step)});                   // RQ21
    wire signed [49:0] wide    = {{9{product[40]}}, product} <<< 9;
    wire signed [49:0] scaled  = wide >>> (6'd9 + shift_amt);
    // Peaks held below converter overload, lower when corrected
    wire [23:0] peak = cur_corr ? `CMG_PEAK_CORR : `CMG_PEAK_FULL;  // RQ8
    wire signed [49:0] peak_w = $signed({26'h0, peak});
    wire signed [23:0] limited = scaled > peak_w ? $signed(peak) :
                                 scaled < -peak_w ? -$signed(peak) :
                                 scaled[23:0];                      // RQ8

    assign in_ready = !out_valid || out_ready;

    // Latch block gain and block state at each block start
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            blk_gain  <= 11'sd0;
            blk_dmx   <= 1'b0;
            blk_mod   <= 1'b0;
            blk_heavy <= 1'b0;
        end else if (new_block) begin
            blk_gain  <= next_gain;                                 // RQ21
            blk_dmx   <= in_downmix;
            blk_mod   <= mod_mode;
            blk_heavy <= use_heavy;
        end
    end

    // Output register
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            out_valid  <= 1'b0;
            out_sample <= 24'sh0;
            out_chan   <= 3'h0;
        end else if (take) begin
            out_valid  <= !drop;                                    // RQ20
            out_sample <= limited;
            out_chan   <= in_chan;
        end else if (out_ready) begin
            out_valid  <= 1'b0;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    chk_mod_full_scale: assert property (@(posedge ref_clk) // RQ6
        disable iff (!reset_n)
        mod_mode |-> (eff_high == 4'ha && eff_low == 4'ha))
        else $error("scale factors not full in modulator mode");

    chk_std_preset: assert property (@(posedge ref_clk) // RQ10
        disable iff (!reset_n)
        (preset == CMG_PRE_STD && !rf_only) |->
        (!mod_mode && eff_high == 4'ha && eff_low == 4'ha && corr_db == 0))
        else $error("standard preset not 1.0/1.0 line");

    chk_max_preset: assert property (@(posedge ref_clk) // RQ13
        disable iff (!reset_n)
        preset == CMG_PRE_MAX |-> (eff_high == 4'h0 && eff_low == 4'h0))
        else $error("maximum preset not 0.0/0.0");

    chk_rf_only_min: assert property (@(posedge ref_clk) // RQ12
        disable iff (!reset_n)
        rf_only |-> mod_mode)
        else $error("modulated-only source left modulator mode");

    chk_heavy_fallback: assert property (@(posedge ref_clk) // RQ5
        disable iff (!reset_n)
        (mod_mode && !in_heavy_present) |->
        comp_word == $signed(in_light_word))
        else $error("light word not used when heavy word absent");

    chk_mode_shift: assert property (@(posedge ref_clk) // RQ7
        disable iff (!reset_n)
        mode_db == (mod_mode ? 11'sd44 : 11'sd0))
        else $error("modulator gain shift wrong");

    chk_dec_corr: assert property (@(posedge ref_clk) // RQ15
        disable iff (!reset_n)
        (mod_mode && decoder) |-> corr_db == 11'sd44)
        else $error("decoder correction missing");

    chk_lfe_dropped: assert property (@(posedge ref_clk) // RQ20
        disable iff (!reset_n)
        (take && drop) |=> !out_valid)
        else $error("effects channel passed during downmix");

    chk_block_gain: assert property (@(posedge ref_clk) // RQ21
        disable iff (!reset_n)
        new_block |=> (blk_gain == $past(next_gain)))
        else $error("block gain not latched at block start");

    chk_gain_steady: assert property (@(posedge ref_clk) // RQ21
        disable iff (!reset_n)
        !new_block |=> $stable(blk_gain))
        else $error("block gain changed inside a block");

    chk_cut_downmix: assert property (@(posedge ref_clk) // RQ3
        disable iff (!reset_n)
        (in_downmix && comp_word[7]) |-> sel_fac == 4'ha)
        else $error("cut scaled while downmixing");

    chk_bus_wait: assert property (@(posedge ref_clk)
        disable iff (!reset_n)
        $rose(bus_req) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("bus answer not after one wait state");

endmodule

//--- cmg_defines.svh
// Offsets, field positions, reset values and gain constants for the gain stage
`ifndef CMG_DEFINES_SVH
`define CMG_DEFINES_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define CMG_OFS_CTRL        4'h0
`define CMG_OFS_SCALE       4'h4
`define CMG_OFS_STATUS      4'h8

// ****************************************************************
// Field positions
// ****************************************************************
`define CMG_CTRL_MODE_LSB   0
`define CMG_CTRL_PRESET_LSB 2
`define CMG_CTRL_TANDEM     4
`define CMG_CTRL_DECODER    5
`define CMG_CTRL_SRC_RF     6
`define CMG_CTRL_RF_ONLY    7
`define CMG_SCALE_HIGH_LSB  0
`define CMG_SCALE_LOW_LSB   8

// ****************************************************************
// Reset values
// ****************************************************************
`define CMG_CTRL_RESET      8'h00
`define CMG_SCALE_RESET     4'ha

// ****************************************************************
// Gain constants, dB offsets in quarter dB units
// ****************************************************************
`define CMG_SCALE_FULL      4'ha
`define CMG_LINE_TARGET_DB  11'sd124
`define CMG_MOD_SHIFT_DB    11'sd44
`define CMG_DEC_CORR_DB     11'sd44
`define CMG_DMX_OFFSET_DB   11'sd12
`define CMG_DN_DEFAULT      5'h1f
`define CMG_EXP_BIAS        11'sd480
`define CMG_EXP_MAX         6'sd9
`define CMG_PEAK_FULL       24'h7fffff
`define CMG_PEAK_CORR       24'h24122e
`define CMG_LFE_CHAN        3'h3

`endif

//--- cmg_pkg.sv
// Types shared by the compression and gain stage
package cmg_pkg;
    typedef enum logic [1:0] {
        CMG_OP_LINE   = 2'b00,
        CMG_OP_MOD    = 2'b01,
        CMG_OP_CUSTOM = 2'b10,
        CMG_OP_RSVD   = 2'b11
    } cmg_op_t;

    typedef enum logic [1:0] {
        CMG_PRE_STD = 2'b00,
        CMG_PRE_MAX = 2'b01,
        CMG_PRE_MIN = 2'b10,
        CMG_PRE_VAR = 2'b11
    } cmg_preset_t;
endpackage

//--- cmg_audio_peer.sv
// Upstream sample source and downstream converter model for the gain stage
`timescale 1ns/100ps
module cmg_audio_peer (
    input  wire logic               ref_clk,
    output logic                    in_valid,
    input  wire logic               in_ready,
    output logic signed [23:0]      in_sample,
    output logic [2:0]              in_chan,
    output logic                    in_block_start,
    output logic [4:0]              in_dialnorm,
    output logic [7:0]              in_light_word,
    output logic [7:0]              in_heavy_word,
    output logic                    in_heavy_present,
    output logic                    in_downmix,
    input  wire logic               out_valid,
    output logic                    out_ready,
    input  wire logic signed [23:0] out_sample,
    input  wire logic [2:0]         out_chan,
    input  wire logic               slow
);
    logic [23:0] got_s[$];
    logic [2:0]  got_c[$];

    // ****************************************************************
    // Source side
    // ****************************************************************
    initial begin
        in_valid = 1'b0;
        in_sample = 24'h0;
        in_chan = 3'h0;
        in_block_start = 1'b0;
        in_dialnorm = 5'h1f;
        in_light_word = 8'h0;
        in_heavy_word = 8'h0;
        in_heavy_present = 1'b0;
        in_downmix = 1'b0;
        out_ready = 1'b1;
    end

    // Offers one sample, held until taken; caller is just past an edge
    task send(input logic bs, input logic [2:0] ch, input logic [23:0] s,
              input logic [4:0] dn, input logic [7:0] lw,
              input logic [7:0] hw, input logic hp, input logic dm);
        in_valid <= 1'b1;
        in_sample <= s;
        in_chan <= ch;
        in_block_start <= bs;
        in_dialnorm <= dn;
        in_light_word <= lw;
        in_heavy_word <= hw;
        in_heavy_present <= hp;
        in_downmix <= dm;
        do @(posedge ref_clk); while (in_ready !== 1'b1);
    endtask

    // Released stream shows the inverse of the last sample
    task idle();
        in_valid <= 1'b0;
        in_block_start <= 1'b0;
        in_sample <= ~in_sample;
    endtask

    // ****************************************************************
    // Converter side
    // ****************************************************************
    // Takes each transfer at its edge; stalls every other cycle when slow
    always @(posedge ref_clk) begin
        if (out_valid === 1'b1 && out_ready === 1'b1) begin
            got_s.push_back(out_sample);
            got_c.push_back(out_chan);
        end
        out_ready <= slow ? ~out_ready : 1'b1;
    end
endmodule

//--- cmg_gain_stage_tb.sv
// Self-checking bench for the compression and gain stage
`timescale 1ns/100ps
module cmg_gain_stage_tb;
    logic        ref_clk, reset_n, avs_read, avs_write, slow;
    logic [3:0]  avs_address, avs_byteenable;
    logic [31:0] avs_writedata;
    wire  [31:0] avs_readdata;
    wire         avs_waitrequest, in_valid, in_ready, in_block_start;
    wire         in_heavy_present, in_downmix, out_valid, out_ready;
    wire  signed [23:0] in_sample, out_sample;
    wire  [2:0]  in_chan, out_chan;
    wire  [4:0]  in_dialnorm;
    wire  [7:0]  in_light_word, in_heavy_word;
    int          fails, n_tests, cyc;
    logic [23:0] xs[$], es[$];
    logic [2:0]  ec[$];
    logic [31:0] q;

    cmg_gain_stage cmg_gain_stage_i (.ref_clk, .reset_n, .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
        .avs_readdata, .avs_waitrequest, .in_valid, .in_ready, .in_sample,
        .in_chan, .in_block_start, .in_dialnorm, .in_light_word,
        .in_heavy_word, .in_heavy_present, .in_downmix, .out_valid,
        .out_ready, .out_sample, .out_chan);
    cmg_audio_peer cmg_audio_peer_i (.ref_clk, .in_valid, .in_ready,
        .in_sample, .in_chan, .in_block_start, .in_dialnorm, .in_light_word,
        .in_heavy_word, .in_heavy_present, .in_downmix, .out_valid,
        .out_ready, .out_sample, .out_chan, .slow);

    // ****************************************************************
    // Clock, timeout and reporting
    // ****************************************************************
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // Cuts a hang short
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            close_out();
        end
    end

    task close_out();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task chk_smp(input string nm, input logic [23:0] e, input logic [23:0] g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // ****************************************************************
    // Avalon-MM master and stream helpers
    // ****************************************************************
    // Holds the request until waitrequest is seen low at an edge
    task bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
             input logic [3:0] be, output logic [31:0] rd);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= d;
        avs_byteenable <= be;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        {avs_write, avs_read, avs_address, avs_writedata} <= {2'b00, ~a, ~d};
        @(posedge ref_clk);
    endtask

    task rd_chk(input logic [3:0] a, input logic [31:0] e, input string nm);
        bus(1'b0, a, 32'h0, 4'hf, q);
        chk_reg(nm, e, q);
    endtask

    task wait_out(input int n);
        while (cmg_audio_peer_i.got_s.size() < n) @(posedge ref_clk);
    endtask

    // Streams xs as one block, then compares count and channels with ec, and samples with es only when vals is set
    task play(input logic [7:0] c, input logic dm, input logic vals);
        int i;
        bus(1'b1, 4'h0, {24'h0, c}, 4'hf, q);
        for (i = 0; i < xs.size(); i++)
            cmg_audio_peer_i.send(i == 0, i[2:0], xs[i], 5'h1f, 8'h0, 8'h0,
                                  1'b0, dm);
        cmg_audio_peer_i.idle();
        wait_out(ec.size());
        repeat (4) @(posedge ref_clk);
        chk_reg("count", ec.size(), cmg_audio_peer_i.got_s.size());
        for (i = 0; i < ec.size(); i++) begin
            if (vals)
                chk_smp("sample", es[i], cmg_audio_peer_i.got_s[i]);
            chk_smp("chan", ec[i], cmg_audio_peer_i.got_c[i]);
        end
        cmg_audio_peer_i.got_s.delete();
        cmg_audio_peer_i.got_c.delete();
    endtask

    // One-sample block, then block status against the expected gain
    task run_case(input logic [7:0] c, input logic [11:0] sc,
                  input logic [4:0] dn, input logic [7:0] lw,
                  input logic [7:0] hw, input logic hp, input logic dm,
                  input logic [2:0] st, input int g);
        bus(1'b1, 4'h0, {24'h0, c}, 4'hf, q);
        bus(1'b1, 4'h4, {20'h0, sc}, 4'hf, q);
        cmg_audio_peer_i.send(1'b1, 3'h0, 24'h000100, dn, lw, hw, hp, dm);
        cmg_audio_peer_i.idle();
        wait_out(1);
        cmg_audio_peer_i.got_s.delete();
        cmg_audio_peer_i.got_c.delete();
        rd_chk(4'h8, {5'h0, g[10:0], 13'h0, st}, "status");
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        fails = 0;
        n_tests = 0;
        slow = 1'b1;
        reset_n = 1'b0;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
        repeat (8) @(posedge ref_clk);
        reset_n <= 1'b1;
        rd_chk(4'h0, 32'h0, "ctrl");
        rd_chk(4'h4, 32'h00000a0a, "scale");
        rd_chk(4'h8, 32'h0, "status");
        bus(1'b1, 4'h8, 32'hffffffff, 4'hf, q);
        rd_chk(4'h8, 32'h0, "status ro");
        bus(1'b1, 4'hc, 32'hffffffff, 4'hf, q);
        rd_chk(4'hc, 32'h0, "unmapped");
        bus(1'b1, 4'h4, 32'h00000303, 4'h1, q);
        rd_chk(4'h4, 32'h00000a03, "scale lane");
        run_case(8'h00, 12'h505, 31, 8'h00, 8'hd8, 1, 0, 3'h0, 0);
        run_case(8'h00, 12'h505, 20, 8'h00, 8'h00, 0, 0, 3'h0, -44);
        run_case(8'h00, 12'h505, 0, 8'h00, 8'h00, 0, 0, 3'h0, 0);
        run_case(8'h00, 12'h505, 31, 8'h00, 8'h00, 0, 1, 3'h2, -12);
        run_case(8'h00, 12'h505, 31, 8'hd8, 8'h00, 0, 0, 3'h0, -40);
        run_case(8'h04, 12'ha0a, 31, 8'hd8, 8'h00, 0, 0, 3'h0, 0);
        run_case(8'h24, 12'ha0a, 31, 8'hd8, 8'h00, 0, 0, 3'h0, 0);
        run_case(8'h0c, 12'h505, 31, 8'hd8, 8'h00, 0, 0, 3'h0, -20);
        run_case(8'h0c, 12'h505, 31, 8'hd8, 8'h00, 0, 1, 3'h2, -52);
        run_case(8'h0c, 12'h505, 31, 8'h14, 8'h00, 0, 0, 3'h0, 10);
        run_case(8'h0c, 12'h000, 31, 8'h14, 8'h00, 0, 0, 3'h0, 0);
        run_case(8'h0c, 12'ha0a, 31, 8'hd8, 8'h00, 0, 0, 3'h0, -40);
        run_case(8'h0c, 12'hf0f, 31, 8'hd8, 8'h00, 0, 0, 3'h0, -40);
        run_case(8'h1c, 12'ha05, 31, 8'h14, 8'h00, 0, 0, 3'h0, 10);
        run_case(8'h0e, 12'h505, 31, 8'hd8, 8'h00, 0, 0, 3'h0, -20);
        run_case(8'h0f, 12'h505, 31, 8'hd8, 8'h00, 0, 0, 3'h0, -20);
        run_case(8'h0d, 12'h505, 31, 8'h00, 8'hd8, 1, 0, 3'h5, 4);
        run_case(8'h0d, 12'h505, 31, 8'hd8, 8'h00, 0, 0, 3'h1, 4);
        run_case(8'h0d, 12'h505, 20, 8'h00, 8'h00, 0, 0, 3'h1, 0);
        run_case(8'h0d, 12'h505, 31, 8'h00, 8'h00, 0, 1, 3'h3, 32);
        run_case(8'h2d, 12'h505, 31, 8'h00, 8'hd8, 1, 0, 3'h5, -40);
        run_case(8'h08, 12'h505, 31, 8'h00, 8'h00, 0, 0, 3'h1, 44);
        run_case(8'h80, 12'h505, 31, 8'h00, 8'h00, 0, 0, 3'h1, 44);
        xs = {24'h123456, 24'hedcba9, 24'h7fffff, 24'h800001, 24'h1,
              24'hffffff};
        es = xs;
        ec = {3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5};
        play(8'h00, 1'b0, 1'b1);
        ec = {3'h0, 3'h1, 3'h2, 3'h4, 3'h5};
        play(8'h00, 1'b1, 1'b0);
        xs = {24'h7fffff, 24'h800001, 24'h100000};
        es = {24'h24122e, 24'hdbedd2, 24'h100000};
        ec = {3'h0, 3'h1, 3'h2};
        play(8'h2d, 1'b0, 1'b1);
        xs = {24'h400000, 24'hc00000};
        es = {24'h7fffff, 24'h800001};
        ec = {3'h0, 3'h1};
        play(8'h0d, 1'b0, 1'b1);
        close_out();
    end
endmodule
